// file: core/fpcl_device.sv
// fpcl_device: configuration-side end of the fast parallel load link
// assumes the host drives request, clock and data asynchronously; all pins synchronised
// How it works
// - 8-bit words: one edge, two with decompression
// - wider words: one, two secure, four decompressing
// - host holds request low at least 2 us
// - status low within 600 ns of request
// - complete low within 600 ns of request
// - status low 268 us min, 1506 us max
// - status released within 1506 us of request high
// - external low hold delays start; device waits
// - host waits 2 us after status high
// - host clock at most 125 / 100 MHz
// - internal init: user mode 175..437 us after complete
// - user init: cd2cu plus 8576 user periods
// - sequence timings assume one edge per word
module fpcl_device
    import fpcl_pkg::*;
#(
    parameter int DW = 32,
    parameter int WORDS = 16,
    parameter int STATUS_CYC = CYC_STATUS_MIN + 40,
    parameter int INIT_CYC = CYC_CD2UM_MIN + 40
) (
    input wire logic clk_sys_i,          // system clock
    input wire logic rstn_i,             // async reset, active low
    fpcl_if.device lnk,                  // link pins
    input wire logic [1:0] width_i,      // load width select
    input wire logic decomp_i,           // decompression enabled
    input wire logic secure_i,           // design security enabled
    input wire logic user_init_i,        // init from user clock
    input wire logic user_init_clock_i,  // user init clock
    output logic [DW-1:0] word_o,        // last received word
    output logic word_valid_o,           // word received pulse
    output logic user_mode_o             // device in user mode
);
    // reset lasts one cycle; hold covers the whole status low time
    typedef enum logic [2:0] {
        S_RESET,
        S_HOLD,
        S_WAIT,
        S_LOAD,
        S_INIT,
        S_USER
    } fpcl_dev_state_t;

    // two-flop synchronisers; the _d stage only feeds the edge finders
    logic req_m, req_s;
    logic clk_m, clk_s, clk_d;
    logic st_m, st_s;
    logic uc_m, uc_s, uc_d;
    logic [DW-1:0] dat_m, dat_s;
    fpcl_dev_state_t state_ff, nxt_state;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [2:0] rep_ff, nxt_rep;
    logic [15:0] words_ff, nxt_words;
    logic [DW-1:0] word_ff, nxt_word;
    logic vld_ff, nxt_vld;
    logic rise, urise;
    logic [2:0] ratio;

    // data crosses through the same two stages as its clock, so a word set up
    // a full system cycle before the clock rise is seen whole at the edge
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            req_m <= 1'b1;
            req_s <= 1'b1;
            clk_m <= 1'b0;
            clk_s <= 1'b0;
            clk_d <= 1'b0;
            st_m <= 1'b1;
            st_s <= 1'b1;
            uc_m <= 1'b0;
            uc_s <= 1'b0;
            uc_d <= 1'b0;
            dat_m <= '0;
            dat_s <= '0;
        end else begin
            req_m <= lnk.load_request_n;
            req_s <= req_m;
            clk_m <= lnk.load_clock;
            clk_s <= clk_m;
            clk_d <= clk_s;
            st_m <= lnk.load_state_n;
            st_s <= st_m;
            uc_m <= user_init_clock_i;
            uc_s <= uc_m;
            uc_d <= uc_s;
            dat_m <= lnk.load_data;
            dat_s <= dat_m;
        end
    end

    // both clocks idle low, as the reset values do: no false edge after reset
    assign rise = clk_s & ~clk_d;
    assign urise = uc_s & ~uc_d;
    // ratio follows the mode inputs live; change them only between loads
    assign ratio = fpcl_ratio(width_i, decomp_i, secure_i);

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_rep = rep_ff;
        nxt_words = words_ff;
        nxt_word = word_ff;
        nxt_vld = 1'b0;
        if (!req_s) begin
            // request low restarts everything, within synchroniser latency
            nxt_state = S_HOLD;
            nxt_cnt = '0;
            nxt_rep = '0;
            nxt_words = '0;
            // last word is kept; the next load overwrites it
        end else begin
            case (state_ff)
                S_RESET: begin
                    // one cycle so the hold count starts clean
                    nxt_state = S_HOLD;
                    nxt_cnt = '0;
                end
                S_HOLD: begin
                    // own low time, counted from request release
                    if (cnt_ff >= CNT_W'(STATUS_CYC - 1)) begin
                        nxt_state = S_WAIT;
                        nxt_cnt = '0;
                    end else begin
                        nxt_cnt = cnt_ff + 1'b1;
                    end
                end
                S_WAIT: begin
                    // the host may keep the line low after our release
                    if (st_s) begin
                        nxt_state = S_LOAD;
                    end
                end
                S_LOAD: begin
                    if (rise) begin
                        // one word per ratio edges; data held by host
                        // the word is taken on the last edge of its group
                        if (rep_ff + 3'h1 >= ratio) begin
                            nxt_rep = '0;
                            nxt_word = dat_s;
                            nxt_vld = 1'b1;
                            nxt_words = words_ff + 1'b1;
                            if (words_ff + 1'b1 >= 16'(WORDS)) begin
                                nxt_state = S_INIT;
                                nxt_cnt = '0;
                            end
                        end else begin
                            nxt_rep = rep_ff + 3'h1;
                        end
                    end
                end
                S_INIT: begin
                    if (user_init_i) begin
                        // cd2cu edges of load clock then user clock periods
                        // the host supplies those edges after it sees complete
                        if (rise && rep_ff < 3'(CD2CU_LOAD_CLOCK_PERIODS)) begin
                            nxt_rep = rep_ff + 3'h1;
                        end else if (urise && rep_ff == 3'(CD2CU_LOAD_CLOCK_PERIODS)) begin
                            nxt_cnt = cnt_ff + 1'b1;
                            if (cnt_ff >= CNT_W'(USER_INIT_PERIODS - 1)) begin
                                nxt_state = S_USER;
                            end
                        end
                    end else if (cnt_ff >= CNT_W'(INIT_CYC - 1)) begin
                        // system cycles stand in for the internal oscillator
                        nxt_state = S_USER;
                    end else begin
                        nxt_cnt = cnt_ff + 1'b1;
                    end
                end
                // only a new request leaves user mode
                S_USER: nxt_state = S_USER;
                default: nxt_state = S_HOLD;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_ff <= S_RESET;
            cnt_ff <= '0;
            rep_ff <= '0;
            words_ff <= '0;
            word_ff <= '0;
            vld_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            rep_ff <= nxt_rep;
            words_ff <= nxt_words;
            word_ff <= nxt_word;
            vld_ff <= nxt_vld;
        end
    end

    // status pulled low during reset and hold; released otherwise
    // open drain: only ever drives low, the pull-up gives the high level
    assign lnk.state_dev_o = 1'b0;
    assign lnk.state_dev_oe = (state_ff == S_RESET) || (state_ff == S_HOLD);
    // complete drops with any restart, so a cut load never reads as done
    assign lnk.load_complete = (state_ff == S_INIT) || (state_ff == S_USER);
    assign word_o = word_ff;
    assign word_valid_o = vld_ff;
    assign user_mode_o = (state_ff == S_USER);
endmodule // fpcl_device

// file: include/fpcl_pkg.sv
// fpcl_pkg: constants and the ratio function shared by both ends of the parallel load link
// assumes a 40 MHz system clock on both ends
package fpcl_pkg;
    localparam int CLK_MHZ = 40;
    localparam int CLK_PERIOD_NS = 25;
    // times as printed
    localparam int T_CFG_US = 2;
    localparam int T_CF2ST0_NS = 600;
    localparam int T_CF2CD_NS = 600;
    localparam int T_STATUS_MIN_US = 268;
    localparam int T_STATUS_MAX_US = 1506;
    localparam int T_CF2ST1_US = 1506;
    localparam int T_ST2CK_US = 2;
    localparam int T_CF2CK_US = 1506;
    localparam int T_CD2UM_MIN_US = 175;
    localparam int T_CD2UM_MAX_US = 437;
    localparam int USER_INIT_PERIODS = 8576;
    localparam int CD2CU_LOAD_CLOCK_PERIODS = 4;
    localparam int LOAD_CLK_MAX_MHZ_NARROW = 125;
    localparam int LOAD_CLK_MAX_MHZ_WIDE = 100;
    // cycle counts: least times round up, longest round down
    localparam int CYC_CFG = (T_CFG_US * CLK_MHZ);
    localparam int CYC_CF2ST0 = T_CF2ST0_NS / CLK_PERIOD_NS;
    localparam int CYC_CF2CD = T_CF2CD_NS / CLK_PERIOD_NS;
    localparam int CYC_STATUS_MIN = T_STATUS_MIN_US * CLK_MHZ;
    localparam int CYC_STATUS_MAX = T_STATUS_MAX_US * CLK_MHZ;
    localparam int CYC_ST2CK = T_ST2CK_US * CLK_MHZ;
    localparam int CYC_CF2CK = T_CF2CK_US * CLK_MHZ;
    localparam int CYC_CD2UM_MIN = T_CD2UM_MIN_US * CLK_MHZ;
    localparam int CYC_CD2UM_MAX = T_CD2UM_MAX_US * CLK_MHZ;
    localparam int CNT_W = 20;
    localparam logic [1:0] WIDTH_8 = 2'h0;
    localparam logic [1:0] WIDTH_16 = 2'h1;
    localparam logic [1:0] WIDTH_32 = 2'h2;

    // clock edges each data word spans, by width and feature setting
    function automatic logic [2:0] fpcl_ratio(input logic [1:0] width,
                                              input logic decomp,
                                              input logic secure);
        if (width == WIDTH_8) begin
            fpcl_ratio = decomp ? 3'h2 : 3'h1;
        end else if (decomp) begin
            fpcl_ratio = 3'h4;
        end else begin
            fpcl_ratio = secure ? 3'h2 : 3'h1;
        end
    endfunction
endpackage

// file: include/fpcl_if.sv
// fpcl_if: pins between the load host and the loaded device
// assumes both ends share one system clock in the bench; open-drain wires resolved here
interface fpcl_if #(parameter int DW = 32);
    logic load_request_n;
    logic load_clock;
    logic [DW-1:0] load_data;
    logic state_dev_o;
    logic state_dev_oe;
    logic state_host_oe;
    logic load_state_n;
    logic load_complete;
    // open-drain status line: pulled high unless either party pulls low
    assign load_state_n = ~((state_dev_oe & ~state_dev_o) | state_host_oe);

    modport device (input load_request_n, input load_clock, input load_data,
                    input load_state_n, output state_dev_o, output state_dev_oe,
                    output load_complete);
    modport host (output load_request_n, output load_clock, output load_data,
                  input load_state_n, output state_host_oe, input load_complete);
endinterface

// file: core/fpcl_host.sv
// fpcl_host: loading host end; pulses request, waits for status, clocks words out
// assumes user side presents words with a valid/ready handshake on clk_sys_i
module fpcl_host
    import fpcl_pkg::*;
#(
    parameter int DW = 32,
    parameter int ST2CK_CYC = CYC_ST2CK,
    parameter int CFG_CYC = CYC_CFG
) (
    input wire logic clk_sys_i,       // system clock
    input wire logic rstn_i,          // async reset, active low
    fpcl_if.host lnk,                 // link pins
    input wire logic start_i,         // begin a load, pulse
    input wire logic hold_i,          // delay start by holding status low
    input wire logic [1:0] width_i,   // load width select
    input wire logic decomp_i,        // decompression enabled
    input wire logic secure_i,        // design security enabled
    input wire logic [DW-1:0] word_i, // next word
    input wire logic word_valid_i,    // word available
    output logic word_ready_o,        // word taken
    output logic done_o               // complete seen high
);
    typedef enum logic [2:0] {H_IDLE, H_PULSE, H_WAIT, H_GAP, H_LOW, H_HIGH} fpcl_host_state_t;

    logic st_m, st_s, cd_m, cd_s;
    fpcl_host_state_t state_ff, nxt_state;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [2:0] rep_ff, nxt_rep;
    logic [2:0] post_ff, nxt_post;
    logic [DW-1:0] dat_ff, nxt_dat;
    logic [2:0] ratio;

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_m <= 1'b0;
            st_s <= 1'b0;
            cd_m <= 1'b0;
            cd_s <= 1'b0;
        end else begin
            st_m <= lnk.load_state_n;
            st_s <= st_m;
            cd_m <= lnk.load_complete;
            cd_s <= cd_m;
        end
    end

    assign ratio = fpcl_ratio(width_i, decomp_i, secure_i);

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_rep = rep_ff;
        nxt_dat = dat_ff;
        nxt_post = post_ff;
        word_ready_o = 1'b0;
        case (state_ff)
            H_IDLE: begin
                if (start_i) begin
                    nxt_state = H_PULSE;
                    nxt_cnt = '0;
                    nxt_rep = '0;
                    nxt_post = '0;
                end
            end
            H_PULSE: begin
                if (cnt_ff >= CNT_W'(CFG_CYC)) begin
                    nxt_state = H_WAIT;
                end else begin
                    nxt_cnt = cnt_ff + 1'b1;
                end
            end
            H_WAIT: begin
                nxt_cnt = '0;
                if (st_s && !hold_i) begin
                    nxt_state = H_GAP;
                end
            end
            H_GAP: begin
                // clock at 10 MHz, well under either ceiling
                if (cnt_ff >= CNT_W'(ST2CK_CYC)) begin
                    nxt_state = H_LOW;
                    nxt_cnt = '0;
                end else begin
                    nxt_cnt = cnt_ff + 1'b1;
                end
            end
            H_LOW: begin
                if (cd_s && post_ff >= 3'(CD2CU_LOAD_CLOCK_PERIODS)) begin
                    nxt_state = H_IDLE;
                end else if (cnt_ff[0]) begin
                    nxt_cnt = '0;
                    nxt_state = H_HIGH;
                    if (cd_s) begin
                        // trailing edges for the device's initialisation
                        nxt_post = post_ff + 3'h1;
                    end
                end else if (cd_s || rep_ff != 3'h0) begin
                    nxt_cnt = cnt_ff + 1'b1;
                end else if (word_valid_i) begin
                    // word set up a full system cycle before the rising edge
                    word_ready_o = 1'b1;
                    nxt_dat = word_i;
                    nxt_cnt = cnt_ff + 1'b1;
                end
            end
            H_HIGH: begin
                if (cnt_ff[0]) begin
                    nxt_cnt = '0;
                    nxt_state = H_LOW;
                    // same word held over ratio rising edges
                    nxt_rep = (rep_ff + 3'h1 >= ratio) ? 3'h0 : rep_ff + 3'h1;
                end else begin
                    nxt_cnt = cnt_ff + 1'b1;
                end
            end
            default: nxt_state = H_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_ff <= H_IDLE;
            cnt_ff <= '0;
            rep_ff <= '0;
            dat_ff <= '0;
            post_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            rep_ff <= nxt_rep;
            dat_ff <= nxt_dat;
            post_ff <= nxt_post;
        end
    end

    assign lnk.load_request_n = (state_ff != H_PULSE);
    assign lnk.load_clock = (state_ff == H_HIGH);
    assign lnk.load_data = dat_ff;
    assign lnk.state_host_oe = hold_i;
    assign done_o = cd_s;
endmodule // fpcl_host

// file: tb/fpcl_chk.sv
// fpcl_chk: timing assertions on the parallel load link pins
// assumes instantiation beside fpcl_if with the device's STATUS_CYC
module fpcl_chk #(
    parameter int DW = 32,
    parameter int STATUS_CYC = 20
) (
    input wire logic clk_sys_i,          // system clock
    input wire logic rstn_i,             // async reset, active low
    input wire logic load_request_n,     // request line
    input wire logic load_clock,         // load clock
    input wire logic [DW-1:0] load_data, // data word
    input wire logic state_dev_oe,       // device pulls status low
    input wire logic load_state_n,       // resolved status line
    input wire logic load_complete       // complete line
);
    localparam int ST_HI = STATUS_CYC + 10;
    logic [7:0] low_ff, nxt_low, high_ff, nxt_high;
    logic [31:0] dev_run_ff, nxt_dev_run;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    // request and status-high run lengths saturate; 8 bits cover the 80-cycle minimums
    always_comb begin
        nxt_low = load_request_n ? 8'h00 : ((low_ff == 8'hFF) ? low_ff : low_ff + 8'h01);
        nxt_high = !load_state_n ? 8'h00 : ((high_ff == 8'hFF) ? high_ff : high_ff + 8'h01);
        nxt_dev_run = state_dev_oe ? dev_run_ff + 32'h1 : 32'h0;
    end
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            low_ff <= 8'h00;
            high_ff <= 8'h00;
            dev_run_ff <= 32'h0;
        end else begin
            low_ff <= nxt_low;
            high_ff <= nxt_high;
            dev_run_ff <= nxt_dev_run;
        end
    end
    chk_request_width: assert property ($rose(load_request_n) |-> low_ff >= 8'h50)
        else $error("request pulse too short");
    chk_status_fast: assert property ($fell(load_request_n) |-> ##[0:24] !load_state_n)
        else $error("status not low in time");
    chk_complete_fast: assert property ($fell(load_request_n) |-> ##[0:24] !load_complete)
        else $error("complete not low in time");
    chk_status_hold: assert property ($rose(load_request_n) |-> state_dev_oe [*8])
        else $error("status released too early");
    chk_status_min: assert property ($fell(state_dev_oe) |-> dev_run_ff >= 32'(STATUS_CYC))
        else $error("status low time too short");
    chk_status_release: assert property ($rose(load_request_n) |-> ##[1:ST_HI] !state_dev_oe)
        else $error("status not released");
    chk_complete_waits: assert property (!load_state_n && !load_complete |=> !load_complete)
        else $error("complete rose while status low");
    chk_clock_start: assert property ($rose(load_clock) |-> high_ff >= 8'h50)
        else $error("clock too soon after status");
    chk_clock_pace: assert property ($rose(load_clock) |=> load_clock)
        else $error("clock high too short");
    chk_data_stable: assert property ($rose(load_clock) |-> $stable(load_data) ##1 $stable(load_data))
        else $error("data moved at clock edge");
    cover property ($rose(load_complete));
    cover property (!state_dev_oe && !load_state_n);
    cover property ($rose(load_clock));
    cover property ($rose(load_clock) && load_complete);
endmodule // fpcl_chk

// file: tb/test_fast_parallel_config_sequence.sv
// test_fast_parallel_config_sequence: host and device joined over fpcl_if
// assumes fpcl_pkg, fpcl_if, both ends and fpcl_chk compiled first
module test_fast_parallel_config_sequence;
    timeunit 1ns;
    timeprecision 1ps;
    import fpcl_pkg::*;
    localparam int WORDS = 4;
    localparam int ST_CYC = 20;
    localparam int IN_CYC = 20;
    localparam logic [31:0] BASE = 32'hA0;
    // {width, decomp, secure, edges per word}
    localparam logic [6:0] ROWS [12] = '{7'h01, 7'h09, 7'h12, 7'h1A, 7'h21, 7'h2A,
                                         7'h34, 7'h3C, 7'h41, 7'h4A, 7'h54, 7'h5C};
    logic clk_sys_i = 1'b0, rstn_i = 1'b0, start = 1'b0, hold = 1'b0;
    logic decomp = 1'b0, secure = 1'b0, lc_ff = 1'b0;
    logic valid = 1'b1, stall = 1'b0, uinit = 1'b0, uclk = 1'b0;
    logic [1:0] width = 2'h0;
    logic [31:0] h_word = 32'h0, d_word;
    logic d_valid, ready, done, umode;
    int errors = 0, checked = 0, sent = 0, rcv = 0;
    int ecnt [16];
    fpcl_if #(.DW(32)) lnk ();
    fpcl_host #(.DW(32)) i_fpcl_host (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .lnk(lnk),
        .start_i(start), .hold_i(hold), .width_i(width), .decomp_i(decomp),
        .secure_i(secure), .word_i(h_word), .word_valid_i(valid), .word_ready_o(ready),
        .done_o(done));
    fpcl_device #(.DW(32), .WORDS(WORDS), .STATUS_CYC(ST_CYC), .INIT_CYC(IN_CYC)) i_fpcl_device (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .lnk(lnk), .width_i(width),
        .decomp_i(decomp), .secure_i(secure), .user_init_i(uinit), .user_init_clock_i(uclk),
        .word_o(d_word), .word_valid_o(d_valid), .user_mode_o(umode));
    fpcl_chk #(.DW(32), .STATUS_CYC(ST_CYC)) i_fpcl_chk (.clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i), .load_request_n(lnk.load_request_n), .load_clock(lnk.load_clock),
        .load_data(lnk.load_data), .state_dev_oe(lnk.state_dev_oe),
        .load_state_n(lnk.load_state_n), .load_complete(lnk.load_complete));
    always #12.5 clk_sys_i = ~clk_sys_i;
    // user init clock of 100 ns; its edges fall on falling system edges
    always #50 uclk = ~uclk;
    // stalling host supply: a word only every other cycle
    always @(negedge clk_sys_i) valid <= !stall || !valid;
    initial begin
        // the user-clock initialisation alone takes about 34k cycles
        #1500000;
        errors++;
        finish_test();
    end
    // rising load clock edges counted per word value seen on the wire
    always @(posedge clk_sys_i) begin
        lc_ff <= lnk.load_clock;
        if (ready === 1'b1) sent <= sent + 1;
        if (lnk.load_clock && !lc_ff && lnk.load_data >= BASE && lnk.load_data < BASE + 32'h10)
            ecnt[lnk.load_data - BASE] <= ecnt[lnk.load_data - BASE] + 1;
        if (d_valid === 1'b1) begin
            check(d_word, BASE + 32'(rcv));
            rcv <= rcv + 1;
        end
    end
    always @(negedge clk_sys_i) h_word <= BASE + 32'(sent);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic do_reset();
        rstn_i = 1'b0;
        sent = 0;
        rcv = 0;
        foreach (ecnt[k]) ecnt[k] = 0;
        repeat (6) @(negedge clk_sys_i);
        rstn_i = 1'b1;
    endtask
    task automatic pulse_start();
        start = 1'b1;
        @(negedge clk_sys_i);
        start = 1'b0;
    endtask
    task automatic load(input logic hold_v, input logic [2:0] r);
        int n;
        int m;
        int lo;
        int hi;
        lo = uinit ? 4 * USER_INIT_PERIODS : IN_CYC - 1;
        hi = uinit ? 4 * USER_INIT_PERIODS + 40 : IN_CYC + 6;
        do_reset();
        hold = hold_v;
        pulse_start();
        if (hold_v) begin
            // host keeps the line low well past the device's own release
            repeat (300) @(negedge clk_sys_i);
            check({31'h0, lnk.load_state_n}, 32'h0);
            check({31'h0, lnk.state_dev_oe}, 32'h0);
            check(32'(ecnt[0]), 32'h0);
            hold = 1'b0;
        end
        m = 0;
        for (n = 0; n < 40000 && umode !== 1'b1; n++) begin
            @(negedge clk_sys_i);
            if (lnk.load_complete === 1'b1) m++;
        end
        check({31'h0, umode}, 32'h1);
        check({31'h0, done}, 32'h1);
        check(32'(m >= lo && m <= hi), 32'h1);
        for (n = 0; n < WORDS; n++) check(32'(ecnt[n]), 32'(r));
        check(32'(rcv), 32'(WORDS));
    endtask
    initial begin
        int n;
        for (int i = 0; i < 12; i++) begin
            {width, decomp, secure} = ROWS[i][6:3];
            load(1'b0, ROWS[i][2:0]);
        end
        load(1'b1, 3'h4);
        // a second start while busy must not stretch the request pulse
        do_reset();
        pulse_start();
        repeat (40) @(negedge clk_sys_i);
        pulse_start();
        repeat (45) @(negedge clk_sys_i);
        check({31'h0, lnk.load_request_n}, 32'h1);
        for (n = 0; n < 400 && lnk.load_clock !== 1'b1; n++) @(negedge clk_sys_i);
        rstn_i = 1'b0;
        @(negedge clk_sys_i);
        check({31'h0, lnk.load_state_n}, 32'h0);
        check({30'h0, lnk.load_clock, lnk.load_complete}, 32'h0);
        {width, decomp, secure} = 4'h0;
        stall = 1'b1;
        load(1'b0, 3'h1);
        // user clock initialisation: cd2cu load edges, then user clock periods
        uinit = 1'b1;
        load(1'b0, 3'h1);
        finish_test();
    end
endmodule // test_fast_parallel_config_sequence
